// [design/cpu_instruction_core.sv]
// Purpose: Four-stage execution core with register banks and stack in IRAM.
// Assumes: Program memory answers fetch_addr combinationally with fetch_word.
// Notes:   One instruction cycle is two clocks; cycle counts are execute occupancy.

`timescale 1ns/1ps
`default_nettype none

module cpu_instruction_core
    import core_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Program memory
    output logic [15:0]       fetch_addr,
    input  wire instr_t       fetch_word,
    // Context and stack configuration
    input  wire logic [15:0]  bank_base_pointer,
    input  wire logic [15:0]  stack_upper_limit,
    input  wire logic [15:0]  stack_lower_limit,
    // Status
    output logic [11:0]       stack_pointer,
    output flags_t            flags,
    output logic [31:0]       muldiv_register_pair,
    output logic              stack_overflow,
    output logic              stack_underflow,
    output logic              retire,
    // Multiply-accumulate path
    output coproc_t           coproc,
    output logic [31:0]       accumulator,
    // Pins
    output logic              reset_output_pin_b,
    input  wire logic         power_down_enable_pin_b,
    output logic              power_down
);

    // ========================================================================
    // Storage and pipeline state
    logic [15:0]        iram [IRAM_WORDS];
    logic [1:0]         phase;
    logic               cycle_en, adv, done, commit, flush;
    logic [15:0]        pc, d_pc, a_pc, e_pc;
    instr_t             d_ins, a_ins, e_ins;
    logic               d_v, a_v, e_v;
    logic [9:0]         e_ra, e_rb, s1_addr, s2_addr, ptr_a, ptr_b;
    logic [4:0]         exec_cnt, cost;
    logic [11:0]        sp_reg, next_sp, sp_m2, sp_m4, sp_p2;
    logic [15:0]        rd_v, rs_v, res, target, pop0, pop1, s1_data, s2_data;
    logic               wb_en, s1_en, s2_en, taken, push, pop, md_en, flag_en;
    logic [31:0]        next_md;
    logic signed [31:0] mul_p, acc_p;
    logic [16:0]        diff;
    logic [3:0]         sh;
    logic               jc_v, jc_hit;
    logic [15:0]        jc_tag, jc_tgt;

    localparam logic [1:0] PH_LAST = 2'(CLK_PER_ICYCLE - 1);

    // Bank-relative word address; wraps so banks may overlap anywhere
    function automatic logic [9:0] reg_addr(input logic [3:0] idx);
        reg_addr = bank_base_pointer[10:1] + {6'h00, idx};
    endfunction

    // Left shifts needed to bring the top set bit to bit 15
    function automatic logic [4:0] norm_count(input logic [15:0] w);
        norm_count = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (w[i]) begin
                norm_count = 5'(15 - i);
            end
        end
    endfunction

    // ========================================================================
    // Instruction cycle divider; keeps counting while power-down freezes the rest of the core
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 2'h0;
        end else if (phase == PH_LAST) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign cycle_en = (phase == PH_LAST) && !power_down;
    assign done     = (exec_cnt == cost - 5'h01);
    assign adv      = cycle_en && (!e_v || done);
    assign commit   = adv && e_v;
    assign flush    = commit && taken;
    assign retire   = commit;
    assign fetch_addr    = pc;
    assign stack_pointer = sp_reg;

    // ========================================================================
    // Four-stage pipeline: fetch, decode, address, execute
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc    <= PC_RESET;
            d_v   <= 1'b0;
            a_v   <= 1'b0;
            e_v   <= 1'b0;
            d_ins <= '0;
            a_ins <= '0;
            e_ins <= '0;
            d_pc  <= '0;
            a_pc  <= '0;
            e_pc  <= '0;
            e_ra  <= '0;
            e_rb  <= '0;
        end else if (flush) begin
            pc  <= target;
            d_v <= 1'b0;
            a_v <= 1'b0;
            e_v <= 1'b0;
        end else if (adv) begin
            pc    <= pc + 16'h0001;
            d_ins <= fetch_word;
            d_pc  <= pc;
            d_v   <= 1'b1;
            a_ins <= d_ins;
            a_pc  <= d_pc;
            a_v   <= d_v;
            e_ins <= a_ins;
            e_pc  <= a_pc;
            e_v   <= a_v;
            e_ra  <= reg_addr(a_ins.rd);
            e_rb  <= reg_addr(a_ins.rs);
        end
    end

    // Occupancy counter holds the pipeline for multi-cycle operations
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exec_cnt <= 5'h00;
        end else if (cycle_en) begin
            exec_cnt <= (e_v && !done) ? exec_cnt + 5'h01 : 5'h00;
        end
    end

    // ========================================================================
    // Execute stage operand reads
    assign rd_v  = iram[e_ra];
    assign rs_v  = iram[e_rb];
    assign sh    = e_ins.imm[3:0];
    assign sp_m2 = sp_reg - 12'h002;
    assign sp_m4 = sp_reg - 12'h004;
    assign sp_p2 = sp_reg + 12'h002;
    assign s1_addr = sp_m2[10:1];
    assign s2_addr = sp_m4[10:1];
    assign pop0  = iram[sp_reg[10:1]];
    assign pop1  = iram[sp_p2[10:1]];
    assign diff  = {1'b0, rd_v} - {1'b0, rs_v};
    assign mul_p = $signed(rd_v) * $signed(rs_v);
    assign ptr_a = rd_v[10:1] + {5'h00, exec_cnt};
    assign ptr_b = rs_v[10:1] + {5'h00, exec_cnt};
    assign acc_p = $signed(iram[ptr_a]) * $signed(iram[ptr_b]);
    assign jc_hit = jc_v && (jc_tag == e_pc) && (jc_tgt == target);

    // Operation decode and result selection
    always_comb begin
        res     = rd_v;
        wb_en   = 1'b0;
        s1_en   = 1'b0;
        s2_en   = 1'b0;
        s1_data = rd_v;
        s2_data = e_pc + 16'h0001;
        next_sp = sp_reg;
        push    = 1'b0;
        pop     = 1'b0;
        taken   = 1'b0;
        target  = e_pc + e_ins.imm;
        cost    = SINGLE_CYCLES;
        md_en   = 1'b0;
        next_md = muldiv_register_pair;
        flag_en = 1'b0;
        case (e_ins.op)
            OP_ADD:  begin res = rd_v + rs_v; wb_en = 1'b1; end
            OP_SUB:  begin res = diff[15:0]; wb_en = 1'b1; end
            OP_AND:  begin res = rd_v & rs_v; wb_en = 1'b1; end
            OP_OR:   begin res = rd_v | rs_v; wb_en = 1'b1; end
            OP_XOR:  begin res = rd_v ^ rs_v; wb_en = 1'b1; end
            OP_MOV:  begin res = rs_v; wb_en = 1'b1; end
            OP_MOVI: begin res = e_ins.imm; wb_en = 1'b1; end
            OP_SHL:  begin res = rd_v << sh; wb_en = 1'b1; end
            OP_SHR:  begin res = rd_v >> sh; wb_en = 1'b1; end
            OP_ROL:  begin
                res = (rd_v << sh) | (rd_v >> (5'h10 - {1'b0, sh}));
                wb_en = 1'b1;
            end
            OP_ROR:  begin
                res = (rd_v >> sh) | (rd_v << (5'h10 - {1'b0, sh}));
                wb_en = 1'b1;
            end
            OP_SHRA: begin res = 16'($signed(rd_v) >>> sh); wb_en = 1'b1; end
            OP_MUL:  begin next_md = mul_p; md_en = 1'b1; cost = MUL_CYCLES; end
            OP_DIV:  begin
                // Short divide: low half is the dividend; divide by zero keeps the pair
                cost  = DIV_CYCLES;
                md_en = (rs_v != 16'h0000);
                if (md_en) begin
                    next_md = {muldiv_register_pair[15:0] % rs_v,
                               muldiv_register_pair[15:0] / rs_v};
                end
            end
            OP_DIVLONG: begin
                cost  = DIV_CYCLES;
                md_en = (rs_v != 16'h0000);
                if (md_en) begin
                    next_md = {16'(muldiv_register_pair % {16'h0000, rs_v}),
                               16'(muldiv_register_pair / {16'h0000, rs_v})};
                end
            end
            OP_NORM: begin res = {11'h000, norm_count(rs_v)}; wb_en = 1'b1; end
            OP_CMPDEC1: begin res = rd_v - 16'h0001; wb_en = 1'b1; flag_en = 1'b1; end
            OP_CMPDEC2: begin res = rd_v - 16'h0002; wb_en = 1'b1; flag_en = 1'b1; end
            OP_CMPINC1: begin res = rd_v + 16'h0001; wb_en = 1'b1; flag_en = 1'b1; end
            OP_CMPINC2: begin res = rd_v + 16'h0002; wb_en = 1'b1; flag_en = 1'b1; end
            OP_JMP:  taken = (e_ins.rd == COND_ALWAYS) || (e_ins.rd == COND_ZERO && flags.z)
                          || (e_ins.rd == COND_NZERO && !flags.z);
            OP_JMPCLR: begin
                taken = rd_v[e_ins.rs];
                res   = rd_v & ~(16'h0001 << e_ins.rs);
                wb_en = taken;
            end
            OP_JMPSET: begin
                taken = !rd_v[e_ins.rs];
                res   = rd_v | (16'h0001 << e_ins.rs);
                wb_en = taken;
            end
            OP_MOVSX: begin res = {{8{rs_v[7]}}, rs_v[7:0]}; wb_en = 1'b1; end
            OP_MOVZX: begin res = {8'h00, rs_v[7:0]}; wb_en = 1'b1; end
            OP_CTXSW: begin
                s1_en = 1'b1;
                push  = 1'b1;
                next_sp = sp_m2;
                res   = e_ins.imm;
                wb_en = 1'b1;
            end
            OP_PUSH: begin s1_en = 1'b1; push = 1'b1; next_sp = sp_m2; end
            OP_POP:  begin res = pop0; wb_en = 1'b1; pop = 1'b1; next_sp = sp_p2; end
            OP_PUSHCALL: begin
                // Register below the return address so the return pops both
                s1_en = 1'b1;
                s2_en = 1'b1;
                push  = 1'b1;
                next_sp = sp_m4;
                taken = 1'b1;
                target = e_ins.imm;
            end
            OP_RETPOP: begin
                taken  = 1'b1;
                target = pop0;
                res    = pop1;
                wb_en  = 1'b1;
                pop    = 1'b1;
                next_sp = sp_reg + 12'h004;
            end
            OP_SWINT: begin
                s1_en   = 1'b1;
                s1_data = e_pc + 16'h0001;
                push    = 1'b1;
                next_sp = sp_m2;
                taken   = 1'b1;
                target  = {7'h00, e_ins.imm[6:0], 2'h0};
            end
            OP_BFHI: begin
                res = {(rd_v[15:8] & ~e_ins.imm[7:0]) | (e_ins.imm[15:8] & e_ins.imm[7:0]),
                       rd_v[7:0]};
                wb_en = 1'b1;
            end
            OP_BFLO: begin
                res = {rd_v[15:8],
                       (rd_v[7:0] & ~e_ins.imm[7:0]) | (e_ins.imm[15:8] & e_ins.imm[7:0])};
                wb_en = 1'b1;
            end
            OP_MACC: cost = {1'b0, e_ins.imm[3:0]} + 5'h01;
            default: ;
        endcase
        if (taken) begin
            cost = jc_hit ? CACHED_JUMP_CYCLES : BRANCH_CYCLES;
        end
    end

    // ========================================================================
    // IRAM writes: stack pushes first, register write last so it wins
    always_ff @(posedge clk) begin
        if (commit && s1_en) begin
            iram[s1_addr] <= s1_data;
        end
        if (commit && s2_en) begin
            iram[s2_addr] <= s2_data;
        end
        if (commit && wb_en) begin
            iram[e_ra] <= res;
        end
    end

    // Stack pointer and limit checks on every push and pop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sp_reg          <= SP_RESET;
            stack_overflow  <= 1'b0;
            stack_underflow <= 1'b0;
        end else begin
            if (commit) begin
                sp_reg <= next_sp;
            end
            stack_overflow  <= commit && push && ({4'h0, next_sp} < stack_upper_limit);
            stack_underflow <= commit && pop && ({4'h0, next_sp} > stack_lower_limit);
        end
    end

    // Multiply/divide pair and compare flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            muldiv_register_pair <= 32'h0000_0000;
            flags <= '0;
        end else if (commit) begin
            if (md_en) begin
                muldiv_register_pair <= next_md;
            end
            if (flag_en) begin
                flags <= '{z: diff[15:0] == 16'h0000, n: diff[15], c: diff[16]};
            end
        end
    end

    // Single-entry jump cache, filled by a taken jump that missed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            jc_v   <= 1'b0;
            jc_tag <= 16'h0000;
            jc_tgt <= 16'h0000;
        end else if (flush && !jc_hit) begin
            jc_v   <= 1'b1;
            jc_tag <= e_pc;
            jc_tgt <= target;
        end
    end

    // Operand pair each instruction cycle; repeat steps walk both pointers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coproc      <= '0;
            accumulator <= 32'h0000_0000;
        end else if (cycle_en && e_v && e_ins.op == OP_MACC) begin
            coproc <= '{valid: 1'b1, a: iram[ptr_a], b: iram[ptr_b]};
            accumulator <= ((e_ins.imm[15] && exec_cnt == 5'h00) ? 32'h0000_0000
                            : accumulator) + acc_p;
        end else begin
            coproc.valid <= 1'b0;
        end
    end

    // Reset output and power-down; power-down ignored unless the enable pin is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_output_pin_b <= 1'b0;
            power_down         <= 1'b0;
        end else if (commit) begin
            if (e_ins.op == OP_INITDONE) begin
                reset_output_pin_b <= 1'b1;
            end
            if (e_ins.op == OP_PWRDOWN && !power_down_enable_pin_b) begin
                power_down <= 1'b1;
            end
        end
    end

    // ========================================================================
    // Checks
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence start_s(op_t o);
        cycle_en && e_v && exec_cnt == 5'h00 && e_ins.op == o;
    endsequence

    icycle_period_a: assert property (
        (cycle_en && !power_down) |=> !cycle_en ##1 (cycle_en || power_down))
        else $error("instruction cycle is not two clocks");
    stage_shift_a: assert property (
        (adv && !flush) |=> (e_pc == $past(a_pc)) && (a_pc == $past(d_pc)) && (d_pc == $past(pc)))
        else $error("pipeline stages did not advance together");
    shift_single_a: assert property (
        (cycle_en && e_v && e_ins.op inside {OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_SHRA}) |-> commit)
        else $error("shift did not finish in one cycle");
    mul_time_a: assert property (
        start_s(OP_MUL) |-> (!commit) [*8] ##1 commit)
        else $error("multiply did not take five cycles");
    div_time_a: assert property (
        start_s(OP_DIVLONG) |-> ##16 !commit ##2 commit)
        else $error("divide did not take ten cycles");
    branch_miss_a: assert property (
        (cycle_en && e_v && exec_cnt == 5'h00 && taken && !jc_hit) |-> !commit ##2 commit)
        else $error("uncached branch did not take two cycles");
    jump_hit_a: assert property (
        (cycle_en && e_v && taken && jc_hit) |-> commit ##1 (pc == $past(target)))
        else $error("cached jump did not finish in one cycle");
    stack_limit_a: assert property (
        (commit && push && ({4'h0, next_sp} < stack_upper_limit)) |=> stack_overflow)
        else $error("stack overflow not flagged");
    ctx_switch_a: assert property (
        (commit && e_ins.op == OP_CTXSW) |=> (iram[$past(e_ra)] == $past(e_ins.imm))
            && (stack_pointer == $past(sp_m2)))
        else $error("context switch did not push and load");
    operand_pair_a: assert property (
        (cycle_en && e_v && e_ins.op == OP_MACC) |=> coproc.valid ##1 !coproc.valid)
        else $error("operand pair not delivered");
    init_pin_a: assert property (
        (commit && e_ins.op == OP_INITDONE) |=> reset_output_pin_b)
        else $error("reset output not raised");

endmodule

`default_nettype wire

// [design/core_pkg.sv]
// Purpose: Shared constants and types for the 16-bit execution core.
// Assumes: 40 MHz core clock; one instruction slot per fetched word.
// Notes:   Opcode encoding is local to this core, not a published format.

package core_pkg;

    // ========================================================================
    // Timing
    localparam int CLK_FREQ_MHZ      = 40;
    localparam int INSTR_CYCLE_NS    = 50;
    // Clocks per instruction cycle, derived from the rate (2 at 40 MHz)
    localparam int CLK_PER_ICYCLE    = INSTR_CYCLE_NS * CLK_FREQ_MHZ / 1000;
    // Execute occupancy in instruction cycles
    localparam logic [4:0] SINGLE_CYCLES      = 5'h01;
    localparam logic [4:0] BRANCH_CYCLES      = 5'h02;
    localparam logic [4:0] CACHED_JUMP_CYCLES = 5'h01;
    localparam logic [4:0] MUL_CYCLES         = 5'h05;
    localparam logic [4:0] DIV_CYCLES         = 5'h0A;

    // ========================================================================
    // Memory layout and reset values
    localparam int          BANK_REGS   = 16;
    localparam int          STACK_BYTES = 2048;
    localparam int          IRAM_WORDS  = STACK_BYTES / 2;
    localparam logic [11:0] SP_RESET    = 12'h800;
    localparam logic [15:0] PC_RESET    = 16'h0000;
    localparam logic [3:0]  COND_ALWAYS = 4'h0;
    localparam logic [3:0]  COND_ZERO   = 4'h1;
    localparam logic [3:0]  COND_NZERO  = 4'h2;

    // ========================================================================
    // Operations
    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MOV, OP_MOVI,
        OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_SHRA, OP_MUL, OP_DIV, OP_DIVLONG,
        OP_NORM, OP_CMPDEC1, OP_CMPDEC2, OP_CMPINC1, OP_CMPINC2, OP_JMP,
        OP_JMPCLR, OP_JMPSET, OP_MOVSX, OP_MOVZX, OP_CTXSW, OP_PUSH, OP_POP,
        OP_PUSHCALL, OP_RETPOP, OP_SWINT, OP_BFHI, OP_BFLO, OP_INITDONE,
        OP_PWRDOWN, OP_MACC
    } op_t;

    // One fetched instruction: op, two register indexes, immediate
    typedef struct packed {
        op_t         op;
        logic [3:0]  rd;
        logic [3:0]  rs;
        logic [1:0]  spare;
        logic [15:0] imm;
    } instr_t;

    // Operand pair handed to the multiply-accumulate path
    typedef struct packed {
        logic        valid;
        logic [15:0] a;
        logic [15:0] b;
    } coproc_t;

    typedef struct packed {
        logic z;
        logic n;
        logic c;
    } flags_t;

endpackage

// [dv/prog_mem_model.sv]
// Purpose: Program memory model answering fetch_addr in the same cycle.
// Assumes: The bench fills mem before reset is released.
// Notes:   Only 64 words; upper address bits fold back onto them.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
    import core_pkg::*;
(
    // Fetch port
    input  wire logic [15:0] fetch_addr,
    output instr_t           fetch_word
);
    instr_t mem [0:63];
    // Combinational read, as the core expects no wait state
    assign fetch_word = mem[fetch_addr[5:0]];
endmodule
`default_nettype wire

// [dv/test_cpu_instruction_core.sv]
// Purpose: Self-checking bench for the execution core.
// Assumes: Program memory model holds a short fixed program with random operands.
// Notes:   Retire times give cycle counts; two clocks per instruction cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_cpu_instruction_core;
    import core_pkg::*;
    logic clk = 0, rst_b = 0, pd_pin_b = 1;
    logic [15:0] fetch_addr, a, b, c, d;
    logic [15:0] bbp = 16'h0100;
    instr_t fetch_word;
    logic [11:0] stack_pointer;
    flags_t flags;
    logic [31:0] pair, acc;
    logic ovf, unf, retire, rout_b, pdown;
    coproc_t coproc;
    int seed = 63, n_mismatch = 0, checks = 0, cyc = 0, n_ret = 0, n_ovf = 0, n_unf = 0;
    int n_pair = 0;
    int rt [0:15];
    always #12.5 clk = ~clk;
    cpu_instruction_core cpu_instruction_core_i (.clk(clk), .rst_b(rst_b),
        .fetch_addr(fetch_addr), .fetch_word(fetch_word),
        .bank_base_pointer(bbp), .stack_upper_limit(16'h0800),
        .stack_lower_limit(16'h07FF), .stack_pointer(stack_pointer), .flags(flags),
        .muldiv_register_pair(pair), .stack_overflow(ovf), .stack_underflow(unf),
        .retire(retire), .coproc(coproc), .accumulator(acc),
        .reset_output_pin_b(rout_b), .power_down_enable_pin_b(pd_pin_b),
        .power_down(pdown));
    prog_mem_model prog_mem_model_i (.fetch_addr(fetch_addr), .fetch_word(fetch_word));
    // ========================================================================
    // Monitors: retire times, limit pulses and the hang guard
    always @(posedge clk) begin
        cyc++;
        if (rst_b && retire && n_ret < 16) begin
            rt[n_ret] = cyc;
            n_ret++;
        end
        if (rst_b && ovf) n_ovf++;
        if (rst_b && unf) n_unf++;
        if (rst_b && coproc.valid) n_pair++;
        if (cyc > 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    function automatic instr_t mk(op_t op, logic [3:0] rd, logic [15:0] imm);
        mk = '{op, rd, 4'h2, 2'h0, imm};
    endfunction
    // Expected values worked out from the rules, never from the core
    function automatic logic [31:0] exp_mul(input logic signed [15:0] x,
                                            input logic signed [15:0] y);
        logic signed [31:0] p;
        p = x * y;
        exp_mul = p;
    endfunction
    function automatic logic [31:0] exp_div(input logic [31:0] p, input logic [15:0] dv);
        logic [31:0] q, r;
        q = p / {16'h0000, dv};
        r = p % {16'h0000, dv};
        exp_div = {r[15:0], q[15:0]};
    endfunction
    function automatic logic [31:0] exp_mac(input logic [15:0] x, input logic [15:0] y);
        exp_mac = exp_mul(x, x) + exp_mul(y, y);
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ========================================================================
    // Main sequence
    initial begin
        a = 16'($random(seed));
        b = 16'($random(seed));
        c = 16'($random(seed));
        d = 16'($random(seed)) | 16'h0001; // Divisor kept nonzero
        for (int i = 0; i < 64; i++) prog_mem_model_i.mem[i] = mk(OP_NOP, 4'h0, 16'h0000);
        prog_mem_model_i.mem[0] = mk(OP_MOVI, 4'h1, a);
        prog_mem_model_i.mem[1] = mk(OP_MOVI, 4'h2, b);
        prog_mem_model_i.mem[2] = mk(OP_MUL, 4'h1, 16'h0000);
        prog_mem_model_i.mem[3] = mk(OP_PUSH, 4'h1, 16'h0000);
        prog_mem_model_i.mem[4] = mk(OP_POP, 4'h3, 16'h0000);
        prog_mem_model_i.mem[5] = mk(OP_INITDONE, 4'h0, 16'h0000);
        prog_mem_model_i.mem[6] = mk(OP_PWRDOWN, 4'h0, 16'h0000);
        prog_mem_model_i.mem[8] = mk(OP_PWRDOWN, 4'h0, 16'h0000);
        repeat (3) @(posedge clk);
        `CHK("sp_reset", 12'h800, stack_pointer)
        `CHK("reset_output_pin_reset", 1'b0, rout_b)
        `CHK("fetch_reset", 16'h0000, fetch_addr)
        #2 rst_b = 1;
        $display("test done: reset values");
        // Waiting on the counter itself avoids racing the monitor at the edge
        wait (n_ret >= 4);
        #2;
        `CHK("single_gap", CLK_PER_ICYCLE, rt[1] - rt[0])
        `CHK("mul_gap", int'(MUL_CYCLES) * CLK_PER_ICYCLE, rt[2] - rt[1])
        `CHK("mul_result", exp_mul(a, b), pair)
        `CHK("sp_push", 12'h7FE, stack_pointer)
        $display("test done: multiply and push");
        wait (n_ret >= 7);
        #2 pd_pin_b = 0;
        `CHK("sp_pop", 12'h800, stack_pointer)
        `CHK("ovf_count", 1, n_ovf)
        `CHK("unf_count", 1, n_unf)
        `CHK("reset_output_pin_init", 1'b1, rout_b)
        `CHK("pdown_pin_high", 1'b0, pdown)
        $display("test done: stack limits and end of init");
        wait (n_ret >= 9);
        #2;
        `CHK("pdown_pin_low", 1'b1, pdown)
        repeat (4) @(posedge clk);
        #2;
        `CHK("frozen", 9, n_ret)
        $display("test done: power down");
        // Second run after a reset in mid-run, bank moved up by one word
        rst_b = 0;
        pd_pin_b = 1;
        bbp = 16'h0102;
        n_ret = 0;
        for (int i = 0; i < 64; i++) prog_mem_model_i.mem[i] = mk(OP_NOP, 4'h0, 16'h0000);
        prog_mem_model_i.mem[0] = mk(OP_MOVI, 4'h1, c);
        prog_mem_model_i.mem[1] = mk(OP_MOVI, 4'h2, d);
        prog_mem_model_i.mem[2] = mk(OP_MOVI, 4'h3, d + 16'h0002);
        prog_mem_model_i.mem[3] = mk(OP_MUL, 4'h1, 16'h0000);
        prog_mem_model_i.mem[4] = mk(OP_DIVLONG, 4'h1, 16'h0000);
        // Loop runs three times: a missed jump, a cached jump, then fall through
        prog_mem_model_i.mem[5] = mk(OP_CMPDEC1, 4'h3, 16'h0000);
        prog_mem_model_i.mem[6] = mk(OP_JMP, COND_NZERO, 16'hFFFF);
        prog_mem_model_i.mem[7] = mk(OP_MOVI, 4'h2, 16'h0104);
        prog_mem_model_i.mem[8] = mk(OP_MACC, 4'h2, 16'h8001);
        prog_mem_model_i.mem[9] = mk(OP_CTXSW, 4'h1, 16'h5A5A);
        repeat (3) @(posedge clk);
        `CHK("pdown_reset", 1'b0, pdown)
        `CHK("sp_reset2", 12'h800, stack_pointer)
        #2 rst_b = 1;
        wait (n_ret >= 14);
        #2;
        `CHK("div_gap", int'(DIV_CYCLES) * CLK_PER_ICYCLE, rt[4] - rt[3])
        `CHK("branch_gap", int'(BRANCH_CYCLES) * CLK_PER_ICYCLE, rt[6] - rt[5])
        `CHK("cached_gap", int'(CACHED_JUMP_CYCLES) * CLK_PER_ICYCLE, rt[8] - rt[7])
        `CHK("macc_gap", 2 * CLK_PER_ICYCLE, rt[12] - rt[11])
        `CHK("div_result", exp_div(exp_mul(c, d), d), pair)
        `CHK("loop_count", d - 16'h0001, cpu_instruction_core_i.iram[10'h084])
        `CHK("loop_flags", 3'h4, flags)
        `CHK("bank_shift", 16'h0104, cpu_instruction_core_i.iram[10'h083])
        `CHK("mac_acc", exp_mac(c, 16'h0104), acc)
        `CHK("pair_steps", 2, n_pair)
        `CHK("pair_last", 16'h0104, coproc.b)
        `CHK("ctx_load", 16'h5A5A, cpu_instruction_core_i.iram[10'h082])
        `CHK("ctx_push", c, cpu_instruction_core_i.iram[10'h3FF])
        `CHK("sp_ctx", 12'h7FE, stack_pointer)
        repeat (2) @(posedge clk);
        #2;
        `CHK("ovf_count2", 2, n_ovf)
        $display("test done: divide, jump cache, multiply-accumulate and context switch");
        report_and_stop();
    end
endmodule
`default_nettype wire
